// File: shared/eeprom_wp_pkg.sv
// Purpose: Shared constants and types for the EEPROM write-protection decision logic
// Assumes: One clock domain; byte-level bus events come from the serial front end
// Notes: Flag storage resets to the unprogrammed state
package eeprom_wp_pkg;

   // Device preambles, the upper nibble of the control byte
   localparam logic [3:0] ARRAY_PREAMBLE = 4'hA;
   localparam logic [3:0] CTRL_PREAMBLE = 4'h6;
   // Fixed flag command bytes (read bit clear)
   localparam logic [7:0] SET_REV_BYTE = 8'h62;
   localparam logic [7:0] CLR_REV_BYTE = 8'h66;
   // Field positions in the control byte and word address
   localparam int RW_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int SEL_MSB = 3;
   localparam int PRE_LSB = 4;
   localparam int HALF_BIT = 7;
   localparam int PAGE_BITS = 4;
   // Reset values of the protection flags (unprogrammed)
   localparam logic PERM_RESET = 1'b0;
   localparam logic REV_RESET = 1'b0;
   // Self-timed write cycle
   localparam int CLK_HZ = 10_000_000;
   localparam int WR_CYCLE_MS = 5;
   localparam int WR_CYCLE_CYCLES = WR_CYCLE_MS * (CLK_HZ / 1000);
   localparam int BUSY_W = 16;

   typedef enum {ST_IDLE, ST_ARR_ADDR, ST_ARR_DATA, ST_FLAG_WR, ST_IGNORE} phase_t;

   typedef enum {CMD_NONE, CMD_ARR_RD, CMD_ARR_WR, CMD_SET_PERM, CMD_QRY_PERM,
      CMD_SET_REV, CMD_QRY_REV, CMD_CLR_REV} cmd_t;

   typedef enum {OP_NONE, OP_SET_PERM, OP_SET_REV, OP_CLR_REV} flag_op_t;

   // One received byte from the serial front end
   typedef struct packed {
      logic valid;
      logic [7:0] value;
   } bus_byte_t;

   // Acknowledge decision for a control byte
   typedef struct packed {
      logic valid;
      logic ack;
   } ack_resp_t;

   // Byte commit towards the array
   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [7:0] data;
   } array_wr_t;

endpackage : eeprom_wp_pkg

// File: core/eeprom_write_protect_logic.sv
// Purpose: Decides acknowledge and write acceptance for array and protection-flag commands
// Assumes: Front end gives one-cycle pulses per control byte, data byte and Stop on ref_clk
// Notes: Protect pin and address straps are asynchronous and pass two flip-flops
`timescale 1ns/1ps
`default_nettype none

module eeprom_write_protect_logic #(
   parameter int WR_CYCLES = eeprom_wp_pkg::WR_CYCLE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wp_pin,
   input wire logic [2:0] addr_strap,
   input wire eeprom_wp_pkg::bus_byte_t ctrl_in,
   input wire eeprom_wp_pkg::bus_byte_t byte_in,
   input wire logic stop_seen,
   output var eeprom_wp_pkg::ack_resp_t ctrl_ack,
   output var eeprom_wp_pkg::ack_resp_t byte_ack,
   output var eeprom_wp_pkg::array_wr_t array_wr,
   output logic permanent_soft_protect_flag,
   output logic reversible_soft_protect_flag,
   output logic write_busy
);

   typedef struct packed {
      logic wp_meta;
      logic wp_sync;
      logic [2:0] sel_meta;
      logic [2:0] sel_sync;
      eeprom_wp_pkg::phase_t phase;
      eeprom_wp_pkg::flag_op_t pend_op;
      logic pend_cycle;
      logic [7:0] word_addr;
      logic perm;
      logic rev;
      logic [eeprom_wp_pkg::BUSY_W-1:0] busy_cnt;
      logic busy;
      eeprom_wp_pkg::ack_resp_t c_ack;
      eeprom_wp_pkg::ack_resp_t b_ack;
      eeprom_wp_pkg::array_wr_t wr;
   } state_t;

   localparam logic [eeprom_wp_pkg::BUSY_W-1:0] BUSY_LOAD =
      eeprom_wp_pkg::BUSY_W'(WR_CYCLES - 1);

   state_t st;
   state_t next_st;

   // Sorts a control byte into a command for this device
   function automatic eeprom_wp_pkg::cmd_t decode_cmd(input logic [7:0] b,
      input logic [2:0] sel);
      logic rd;
      logic [3:0] pre;
      logic [7:0] wr_form;
      rd = b[eeprom_wp_pkg::RW_BIT];
      pre = b[7:eeprom_wp_pkg::PRE_LSB];
      wr_form = {b[7:1], 1'b0};
      decode_cmd = eeprom_wp_pkg::CMD_NONE;
      if (pre == eeprom_wp_pkg::ARRAY_PREAMBLE) begin
         if (b[eeprom_wp_pkg::SEL_MSB:eeprom_wp_pkg::SEL_LSB] == sel) begin
            decode_cmd = rd ? eeprom_wp_pkg::CMD_ARR_RD : eeprom_wp_pkg::CMD_ARR_WR;
         end
      end else if (pre == eeprom_wp_pkg::CTRL_PREAMBLE) begin
         // Fixed reversible-flag codes win over a strap that aliases them
         if (wr_form == eeprom_wp_pkg::SET_REV_BYTE) begin
            decode_cmd = rd ? eeprom_wp_pkg::CMD_QRY_REV : eeprom_wp_pkg::CMD_SET_REV;
         end else if (b == eeprom_wp_pkg::CLR_REV_BYTE) begin
            decode_cmd = eeprom_wp_pkg::CMD_CLR_REV;
         end else if (b[eeprom_wp_pkg::SEL_MSB:eeprom_wp_pkg::SEL_LSB] == sel) begin
            decode_cmd = rd ? eeprom_wp_pkg::CMD_QRY_PERM : eeprom_wp_pkg::CMD_SET_PERM;
         end
      end
   endfunction : decode_cmd

   // Whether one array byte may really be written
   function automatic logic byte_allowed(input logic pin_high, input logic perm_f,
      input logic rev_f, input logic [7:0] addr);
      if (pin_high) begin
         byte_allowed = 1'b0;
      end else if (perm_f || rev_f) begin
         byte_allowed = addr[eeprom_wp_pkg::HALF_BIT];
      end else begin
         byte_allowed = 1'b1;
      end
   endfunction : byte_allowed

   // Next-state logic for the whole block
   always_comb begin
      eeprom_wp_pkg::cmd_t cmd;
      logic [7:0] cur_addr;
      next_st = st;
      cmd = decode_cmd(ctrl_in.value, st.sel_sync);
      cur_addr = st.word_addr;
      // Second stage alone reads the first; straps settle before use
      next_st.wp_meta = wp_pin;
      next_st.wp_sync = st.wp_meta;
      next_st.sel_meta = addr_strap;
      next_st.sel_sync = st.sel_meta;
      next_st.c_ack = '0;
      next_st.b_ack = '0;
      next_st.wr.strobe = 1'b0;

      // Self-timed write cycle; inputs are ignored while it runs
      if (st.busy) begin
         if (st.busy_cnt == '0) begin
            next_st.busy = 1'b0;
         end else begin
            next_st.busy_cnt = st.busy_cnt - 1'b1;
         end
      end

      if (st.busy) begin
         // Control bytes are answered with ack clear, which the master sees as a nack
         next_st.phase = eeprom_wp_pkg::ST_IDLE;
         next_st.c_ack.valid = ctrl_in.valid;
      end else if (stop_seen) begin
         // Flags and the write cycle commit only on a clean Stop
         case (st.pend_op)
            eeprom_wp_pkg::OP_SET_PERM: next_st.perm = 1'b1;
            eeprom_wp_pkg::OP_SET_REV: next_st.rev = 1'b1;
            eeprom_wp_pkg::OP_CLR_REV: next_st.rev = 1'b0;
            default: ;
         endcase
         // Cycle runs even when every byte was suppressed
         if (st.pend_cycle) begin
            next_st.busy = 1'b1;
            next_st.busy_cnt = BUSY_LOAD;
         end
         next_st.pend_op = eeprom_wp_pkg::OP_NONE;
         next_st.pend_cycle = 1'b0;
         next_st.phase = eeprom_wp_pkg::ST_IDLE;
      end else if (ctrl_in.valid) begin
         // A repeated Start drops anything not yet committed
         next_st.pend_op = eeprom_wp_pkg::OP_NONE;
         next_st.pend_cycle = 1'b0;
         next_st.c_ack.valid = 1'b1;
         next_st.phase = eeprom_wp_pkg::ST_IGNORE;
         case (cmd)
            eeprom_wp_pkg::CMD_ARR_RD: begin
               next_st.c_ack.ack = 1'b1;
            end
            eeprom_wp_pkg::CMD_ARR_WR: begin
               next_st.c_ack.ack = 1'b1;
               next_st.phase = eeprom_wp_pkg::ST_ARR_ADDR;
            end
            eeprom_wp_pkg::CMD_QRY_PERM: begin
               next_st.c_ack.ack = !st.perm;
            end
            eeprom_wp_pkg::CMD_QRY_REV: begin
               next_st.c_ack.ack = !st.rev;
            end
            eeprom_wp_pkg::CMD_SET_PERM: begin
               next_st.c_ack.ack = !st.perm;
               if (!st.perm) begin
                  next_st.phase = eeprom_wp_pkg::ST_FLAG_WR;
                  next_st.pend_cycle = 1'b1;
                  next_st.pend_op = st.wp_sync ? eeprom_wp_pkg::OP_NONE
                     : eeprom_wp_pkg::OP_SET_PERM;
               end
            end
            eeprom_wp_pkg::CMD_SET_REV: begin
               next_st.c_ack.ack = !st.rev;
               if (!st.rev) begin
                  next_st.phase = eeprom_wp_pkg::ST_FLAG_WR;
                  next_st.pend_cycle = 1'b1;
                  next_st.pend_op = st.wp_sync ? eeprom_wp_pkg::OP_NONE
                     : eeprom_wp_pkg::OP_SET_REV;
               end
            end
            eeprom_wp_pkg::CMD_CLR_REV: begin
               next_st.c_ack.ack = !st.perm;
               if (!st.perm) begin
                  next_st.phase = eeprom_wp_pkg::ST_FLAG_WR;
                  next_st.pend_cycle = 1'b1;
                  next_st.pend_op = st.wp_sync ? eeprom_wp_pkg::OP_NONE
                     : eeprom_wp_pkg::OP_CLR_REV;
               end
            end
            default: begin
               next_st.c_ack.ack = 1'b0;
            end
         endcase
      end else if (byte_in.valid) begin
         next_st.b_ack.valid = 1'b1;
         case (st.phase)
            eeprom_wp_pkg::ST_ARR_ADDR: begin
               next_st.b_ack.ack = 1'b1;
               next_st.word_addr = byte_in.value;
               next_st.phase = eeprom_wp_pkg::ST_ARR_DATA;
            end
            eeprom_wp_pkg::ST_ARR_DATA: begin
               // Every byte is acked; protected ones never reach the array
               next_st.b_ack.ack = 1'b1;
               next_st.pend_cycle = 1'b1;
               next_st.wr.strobe = byte_allowed(st.wp_sync, st.perm, st.rev,
                  cur_addr);
               next_st.wr.addr = cur_addr;
               next_st.wr.data = byte_in.value;
               // Low address bits wrap inside the page
               next_st.word_addr = {cur_addr[7:eeprom_wp_pkg::PAGE_BITS],
                  cur_addr[eeprom_wp_pkg::PAGE_BITS-1:0] + 1'b1};
            end
            eeprom_wp_pkg::ST_FLAG_WR: begin
               next_st.b_ack.ack = 1'b1; // Address and data are don't-care
            end
            default: begin
               next_st.b_ack.ack = 1'b0;
            end
         endcase
      end
   end

   // State register; flags reset to unprogrammed
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.phase <= eeprom_wp_pkg::ST_IDLE;
         st.pend_op <= eeprom_wp_pkg::OP_NONE;
         st.perm <= eeprom_wp_pkg::PERM_RESET;
         st.rev <= eeprom_wp_pkg::REV_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flip-flops
   assign ctrl_ack = st.c_ack;
   assign byte_ack = st.b_ack;
   assign array_wr = st.wr;
   assign permanent_soft_protect_flag = st.perm;
   assign reversible_soft_protect_flag = st.rev;
   assign write_busy = st.busy;

endmodule : eeprom_write_protect_logic

`default_nettype wire

// File: sim/eeprom_bus_master_model.sv
// Purpose: Bus master stand-in that sends byte events to the protect logic
// Assumes: Each event starts 1 ns after a rising edge and lasts one cycle
// Notes: Released byte lines show the inverse of the last byte, never the old one
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_master_model (
   input wire logic ref_clk,
   output var eeprom_wp_pkg::bus_byte_t ctrl_in,
   output var eeprom_wp_pkg::bus_byte_t byte_in,
   output var logic stop_seen,
   input wire eeprom_wp_pkg::ack_resp_t ctrl_ack,
   input wire eeprom_wp_pkg::ack_resp_t byte_ack,
   input wire eeprom_wp_pkg::array_wr_t array_wr,
   input wire logic write_busy
);
   initial begin
      ctrl_in = '0;
      byte_in = '0;
      stop_seen = 1'b0;
   end
   // Control byte; answer sampled in its one-cycle slot
   task automatic ctrl(input logic [7:0] v, output eeprom_wp_pkg::ack_resp_t r);
      @(posedge ref_clk);
      #1 ctrl_in = {1'b1, v};
      @(posedge ref_clk);
      #1 ctrl_in = {1'b0, ~v};
      r = ctrl_ack;
   endtask : ctrl
   // Address or data byte; answer and array commit share one slot
   task automatic put(input logic [7:0] v, output eeprom_wp_pkg::ack_resp_t r,
      output eeprom_wp_pkg::array_wr_t w);
      @(posedge ref_clk);
      #1 byte_in = {1'b1, v};
      @(posedge ref_clk);
      #1 byte_in = {1'b0, ~v};
      r = byte_ack;
      w = array_wr;
   endtask : put
   // Stop closes every transfer, refused ones too; then, when hold is set, the write cycle is waited out
   task automatic stop(input logic hold, output logic b);
      @(posedge ref_clk);
      #1 stop_seen = 1'b1;
      @(posedge ref_clk);
      #1 stop_seen = 1'b0;
      b = write_busy;
      while (hold && write_busy) begin
         @(posedge ref_clk);
         #1;
      end
   endtask : stop
endmodule : eeprom_bus_master_model
`default_nettype wire

// File: sim/eeprom_wp_checker_sva.sv
// Purpose: Port-level checks of the write-protect decision logic
// Assumes: Straps hold still; strap 001 aliases set-rev and is left out
// Notes: One clock domain, so defaults carry clock and reset
`timescale 1ns/1ps
`default_nettype none
module eeprom_wp_checker #(
   parameter int WR_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic wp_pin,
   input wire logic [2:0] addr_strap,
   input wire eeprom_wp_pkg::bus_byte_t ctrl_in,
   input wire eeprom_wp_pkg::bus_byte_t byte_in,
   input wire logic stop_seen,
   input wire eeprom_wp_pkg::ack_resp_t ctrl_ack,
   input wire eeprom_wp_pkg::ack_resp_t byte_ack,
   input wire eeprom_wp_pkg::array_wr_t array_wr,
   input wire logic permanent_soft_protect_flag,
   input wire logic reversible_soft_protect_flag,
   input wire logic write_busy
);
   logic own_cmd;
   int busy_run;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // Permanent-flag command or query at this strap
   assign own_cmd = ctrl_in.value[7:1] == {4'h6, addr_strap} && addr_strap != 3'h1;
   // Length of the current write cycle; too long a run for a repetition count
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_run <= 0;
      end else begin
         busy_run <= write_busy ? busy_run + 1 : 0;
      end
   end
   // Control byte taken while no write cycle runs
   sequence s_take;
      ctrl_in.valid && !write_busy;
   endsequence
   ctrl_slot_a: assert property (ctrl_in.valid |=> ctrl_ack.valid)
      else $error("control byte not answered");
   busy_nack_a: assert property (ctrl_in.valid && write_busy |=> !ctrl_ack.ack)
      else $error("acknowledge during write cycle");
   read_ack_a: assert property (s_take ##0 ctrl_in.value == {4'hA, addr_strap, 1'b1} |=>
      ctrl_ack.ack) else $error("read not acknowledged");
   perm_lock_a: assert property (s_take ##0 permanent_soft_protect_flag &&
      (own_cmd || ctrl_in.value == 8'h66) |=> !ctrl_ack.ack) else $error("locked cmd acked");
   perm_query_a: assert property (s_take ##0 !permanent_soft_protect_flag &&
      own_cmd && ctrl_in.value[0] |=> ctrl_ack.ack) else $error("query not acknowledged");
   rev_lock_a: assert property (s_take ##0 reversible_soft_protect_flag &&
      ctrl_in.value[7:1] == 7'h31 |=> !ctrl_ack.ack) else $error("reversible cmd acked");
   upper_half_a: assert property (array_wr.strobe &&
      (permanent_soft_protect_flag || reversible_soft_protect_flag) |-> array_wr.addr[7])
      else $error("protected byte written");
   strobe_pair_a: assert property (array_wr.strobe |-> byte_ack.valid && byte_ack.ack)
      else $error("commit without acknowledge");
   perm_keep_a: assert property (permanent_soft_protect_flag |=>
      permanent_soft_protect_flag) else $error("permanent flag cleared");
   rev_at_stop_a: assert property (!stop_seen |=>
      $stable(reversible_soft_protect_flag)) else $error("reversible flag moved");
   busy_len_a: assert property ($fell(write_busy) |-> busy_run == WR_CYCLES)
      else $error("write cycle length wrong");
endmodule : eeprom_wp_checker
bind eeprom_write_protect_logic eeprom_wp_checker #(.WR_CYCLES(WR_CYCLES)) u_chk (
   .ref_clk(ref_clk), .resetn(resetn), .wp_pin(wp_pin), .addr_strap(addr_strap),
   .ctrl_in(ctrl_in), .byte_in(byte_in), .stop_seen(stop_seen), .ctrl_ack(ctrl_ack),
   .byte_ack(byte_ack), .array_wr(array_wr), .write_busy(write_busy),
   .permanent_soft_protect_flag(permanent_soft_protect_flag),
   .reversible_soft_protect_flag(reversible_soft_protect_flag));
`default_nettype wire

// File: sim/eeprom_write_protect_logic_test.sv
// Purpose: Self-checking bench for the write-protect decision logic
// Assumes: Straps tied to 000, so 60h/61h address the permanent flag
// Notes: Write cycle shortened to 20 cycles; permanent flag is set last
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_protect_logic_test;
   logic ref_clk;
   logic resetn = 1'b0;
   logic wp_pin = 1'b0;
   logic stop_seen, perm, rev, write_busy;
   eeprom_wp_pkg::bus_byte_t ctrl_in, byte_in;
   eeprom_wp_pkg::ack_resp_t ctrl_ack, byte_ack, r;
   eeprom_wp_pkg::array_wr_t array_wr, w;
   logic b;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   eeprom_write_protect_logic #(.WR_CYCLES(20)) u_dut (
      .ref_clk(ref_clk), .resetn(resetn), .wp_pin(wp_pin), .addr_strap(3'h0),
      .ctrl_in(ctrl_in), .byte_in(byte_in), .stop_seen(stop_seen), .ctrl_ack(ctrl_ack),
      .byte_ack(byte_ack), .array_wr(array_wr), .permanent_soft_protect_flag(perm),
      .reversible_soft_protect_flag(rev), .write_busy(write_busy));
   eeprom_bus_master_model u_master (
      .ref_clk(ref_clk), .ctrl_in(ctrl_in), .byte_in(byte_in), .stop_seen(stop_seen),
      .ctrl_ack(ctrl_ack), .byte_ack(byte_ack), .array_wr(array_wr), .write_busy(write_busy));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Cuts a hang short; whole run needs about 340 cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   task automatic check(input string n, input logic [16:0] s, input logic [16:0] e);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, s);
      end
   endtask : check
   // Flag command or query, closed by Stop whatever the answer
   task automatic flag(input logic [7:0] v, input logic e);
      u_master.ctrl(v, r);
      check("flag ack", {15'h0, r}, {15'h0, 1'b1, e});
      u_master.stop(1'b1, b);
   endtask : flag
   // Byte write; the cycle runs even when the byte is suppressed
   task automatic wr(input logic [7:0] a, input logic s);
      u_master.ctrl(8'hA0, r);
      check("write ack", {15'h0, r}, 17'h3);
      u_master.put(a, r, w);
      check("addr ack", {15'h0, r}, 17'h3);
      u_master.put(8'h5A, r, w);
      check("data ack", {15'h0, r}, 17'h3);
      // Address and data follow every data byte; only the strobe shows suppression
      check("commit", 17'(w), {s, a, 8'h5A});
      u_master.stop(1'b1, b);
      check("busy", {16'h0, b}, 17'h1);
   endtask : wr
   task automatic t_plain();
      u_master.ctrl(8'hA1, r);
      check("read ack", {15'h0, r}, 17'h3);
      // Foreign preamble belongs to another device and is never acknowledged
      u_master.ctrl(8'h50, r);
      check("foreign nack", {15'h0, r}, 17'h2);
      flag(8'h61, 1'b1);
      flag(8'h63, 1'b1);
      wr(8'h05, 1'b1);
      u_master.ctrl(8'hA0, r);
      u_master.put(8'h0F, r, w);
      u_master.put(8'h11, r, w);
      check("page end", 17'(w), {1'b1, 8'h0F, 8'h11});
      u_master.put(8'h22, r, w);
      check("page wrap", 17'(w), {1'b1, 8'h00, 8'h22});
      u_master.stop(1'b0, b);
      u_master.ctrl(8'hA0, r);
      check("poll nack", {15'h0, r}, 17'h2);
      u_master.stop(1'b1, b);
   endtask : t_plain
   task automatic t_rev();
      flag(8'h62, 1'b1);
      check("rev set", {16'h0, rev}, 17'h1);
      flag(8'h63, 1'b0);
      flag(8'h62, 1'b0);
      wr(8'h05, 1'b0);
      wr(8'h85, 1'b1);
   endtask : t_rev
   // Pin high: everything acked, nothing changes; then released
   task automatic t_pin();
      wp_pin = 1'b1;
      repeat (4) @(posedge ref_clk);
      flag(8'h66, 1'b1);
      flag(8'h60, 1'b1);
      check("flags kept", {15'h0, perm, rev}, 17'h1);
      wr(8'h85, 1'b0);
      u_master.ctrl(8'hA1, r);
      check("read ack", {15'h0, r}, 17'h3);
      #1 wp_pin = 1'b0;
      repeat (4) @(posedge ref_clk);
      flag(8'h66, 1'b1);
      check("rev clear", {16'h0, rev}, 17'h0);
   endtask : t_pin
   task automatic t_perm();
      flag(8'h60, 1'b1);
      check("perm set", {16'h0, perm}, 17'h1);
      flag(8'h61, 1'b0);
      flag(8'h60, 1'b0);
      flag(8'h66, 1'b0);
      wr(8'h7F, 1'b0);
   endtask : t_perm
   initial begin
      repeat (3) @(posedge ref_clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge ref_clk);
      t_plain();
      t_rev();
      t_pin();
      t_perm();
      conclude();
   end
endmodule : eeprom_write_protect_logic_test
`default_nettype wire
